// File: common/fpu_cvt_consts.svh
`ifndef FPU_CVT_CONSTS_SVH
`define FPU_CVT_CONSTS_SVH

// ****************************************
// Instruction encoding
// ****************************************
`define OPC_FP_COP      6'h11
`define RS_MOVE_FROM    5'h02
`define RS_MOVE_TO      5'h06
`define FN_CEIL_LONG    6'h0a
`define FN_CEIL_WORD    6'h0e
`define FN_CVT_DOUBLE   6'h21
`define FN_CVT_LONG     6'h25
`define FMT_SINGLE      5'h10
`define FMT_DOUBLE      5'h11
`define FMT_WORD        5'h14
`define FMT_LONG        5'h15

// ****************************************
// Control register map and field layout
// ****************************************
`define FCR_IMPL_IDX    5'h00
`define FCR_CSR_IDX     5'h1f
`define CSR_RESET       32'h0000_0000
`define CSR_RM_LSB      0
`define CSR_FLAG_LSB    2
`define CSR_EN_LSB      7
`define CSR_CAUSE_LSB   12
`define CSR_UNIMPL_BIT  17
`define RM_ROUND_UP     2'h2

// ****************************************
// Arithmetic limits
// ****************************************
`define DBL_BIAS        13'sh3ff
`define SGL_BIAS        13'sh07f
`define LONG_POS_MAX    65'h0_7fff_ffff_ffff_ffff
`define LONG_NEG_MAX    65'h0_8000_0000_0000_0000
`define WORD_POS_MAX    65'h0_0000_0000_7fff_ffff
`define WORD_NEG_MAX    65'h0_0000_0000_8000_0000
`define LONG_DEFAULT    64'h7fff_ffff_ffff_ffff
`define WORD_DEFAULT    64'h0000_0000_7fff_ffff

`endif

// File: common/fpu_cvt_pkg.sv
package fpu_cvt_pkg;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [63:0] fp_source;
    logic [63:0] general_reg_operand;
  } issue_type;

  typedef struct packed {
    logic        en;
    logic [4:0]  idx;
    logic [63:0] data;
  } wr_port_type;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_RESERVED,
    OP_MOVE_FROM,
    OP_MOVE_TO,
    OP_TO_FIXED,
    OP_TO_DOUBLE
  } op_kind_type;

endpackage

// File: src/fp_to_fixed.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpu_cvt_consts.svh"

module fp_to_fixed
  import fpu_cvt_pkg::*;
(
  input  wire logic        is_double,
  input  wire logic [63:0] src,
  input  wire logic [1:0]  rmode,
  input  wire logic        to_long,
  output logic      [63:0] result,
  output logic             invalid,
  output logic             inexact
);

  logic               sign;
  logic               special;
  logic               big;
  logic [52:0]        mant;
  logic signed [12:0] expo;
  logic [63:0]        whole;
  logic [5:0]         sh;
  logic               rnd_bit;
  logic               sticky;
  logic               inc;
  logic [64:0]        mag;
  logic [64:0]        limit;
  logic [63:0]        signed_val;

  always_comb
  begin
    if (is_double)
    begin
      sign    = src[63];
      special = &src[62:52];
      mant    = {|src[62:52], src[51:0]};
      expo    = $signed({2'h0, (src[62:52] == 11'h0) ? 11'h001 : src[62:52]}) - `DBL_BIAS;
    end
    else
    begin
      sign    = src[31];
      special = &src[30:23];
      mant    = {|src[30:23], src[22:0], 29'h0};
      expo    = $signed({5'h0, (src[30:23] == 8'h0) ? 8'h01 : src[30:23]}) - `SGL_BIAS;
    end
    whole   = 64'h0;
    sh      = 6'h0;
    rnd_bit = 1'b0;
    sticky  = 1'b0;
    big     = 1'b0;
    // Exactly -2^63 is the one value with exponent 63 that is legal, and only for long
    if (expo == 13'sd63 && sign && mant == {1'b1, 52'h0})
      whole = 64'h8000_0000_0000_0000;
    else if (expo > 13'sd62)
      big = 1'b1;
    else if (expo >= 13'sd52)
      whole = {11'h0, mant} << 6'(expo - 13'sd52);
    else if (expo >= -13'sd1)
    begin
      sh      = 6'(13'sd52 - expo);
      whole   = {11'h0, mant >> sh};
      rnd_bit = mant[sh - 6'h1];
      sticky  = |(mant & ((53'h1 << (sh - 6'h1)) - 53'h1));
    end
    else
      sticky = |mant;
    unique case (rmode)
      2'h0: inc = rnd_bit & (sticky | whole[0]);
      2'h1: inc = 1'b0;
      2'h2: inc = ~sign & (rnd_bit | sticky);
      2'h3: inc = sign & (rnd_bit | sticky);
    endcase
    mag = {1'b0, whole} + {64'h0, inc};
    if (to_long)
      limit = sign ? `LONG_NEG_MAX : `LONG_POS_MAX;
    else
      limit = sign ? `WORD_NEG_MAX : `WORD_POS_MAX;
    invalid    = special | big | (mag > limit);
    inexact    = ~invalid & (rnd_bit | sticky);
    signed_val = sign ? 64'(~mag + 65'h1) : mag[63:0];
    if (invalid)
      result = to_long ? `LONG_DEFAULT : `WORD_DEFAULT;
    else
      result = to_long ? signed_val : {32'h0, signed_val[31:0]};
  end

endmodule
`default_nettype wire

// File: src/fpu_cvt_unit.sv
// Contract
// - Function 001010, zero bits 20..16: round-up to long
// - Long round-up always rounds toward plus infinity
// - Inf, NaN or out of range is invalid
// - Invalid sets flag; trap or write maximum
// - Function 001110, zero bits 20..16: round-up to word
// - Word round-up ignores configured rounding mode
// - Move-from-control sign-extends word into general register
// - Move-to-control writes low word, upper ignored
// - Status write commits, then enabled cause traps
// - Function 100001 converts single/word/long to double
// - Single or word to double is exact
// - To-double never raises overflow or underflow
// - Function 100101 converts to long, current mode
// - To-double uses current rounding mode
`timescale 1ns/1ps
`default_nettype none
`include "fpu_cvt_consts.svh"

module fpu_cvt_unit
  import fpu_cvt_pkg::*;
#(
  parameter logic [31:0] IMPL_REV = 32'h0000_0a01   // Arbitrary identification value
)
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire issue_type   issue,
  output wr_port_type      fp_register_wr,
  output wr_port_type      general_reg_wr,
  output logic [31:0]      fp_control_status_reg,
  output logic             fp_exception,
  output logic             reserved_instr
);

  // ****************************************
  // Shared arithmetic
  // ****************************************
  function automatic logic [5:0] lead_one(input logic [63:0] m);
    logic [5:0] p;
    p = 6'h0;
    for (int i = 0; i < 64; i++)
      if (m[i])
        p = 6'(i);
    return p;
  endfunction

  // Value m * 2^k to double; returns {inexact, double}
  function automatic logic [64:0] int_to_double(input logic sign,
                                                input logic [63:0] m,
                                                input logic signed [12:0] k,
                                                input logic [1:0] rm);
    logic [5:0]  p;
    logic [63:0] norm;
    logic        g;
    logic        s;
    logic        inc;
    logic [10:0] bexp;
    logic [62:0] body;
    p    = lead_one(m);
    norm = m << (6'h3f - p);
    g    = norm[10];
    s    = |norm[9:0];
    unique case (rm)
      2'h0: inc = g & (s | norm[11]);
      2'h1: inc = 1'b0;
      2'h2: inc = ~sign & (g | s);
      2'h3: inc = sign & (g | s);
    endcase
    bexp = 11'($signed({7'h0, p}) + k + `DBL_BIAS);
    // Carry out of the fraction bumps the exponent, no overflow possible
    body = {bexp, norm[62:11]} + {62'h0, inc};
    if (m == 64'h0)
      return {1'b0, sign, 63'h0};
    return {g | s, sign, body};
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  logic [5:0]  opc;
  logic [4:0]  fmt;
  logic [4:0]  rt_field;
  logic [4:0]  source_fp_reg;
  logic [4:0]  dest_fp_reg;
  logic [5:0]  funct;
  logic        ceil_op;
  logic        fmt_ok;
  op_kind_type op;

  assign opc           = issue.instr[31:26];
  assign fmt           = issue.instr[25:21];
  assign rt_field      = issue.instr[20:16];
  assign source_fp_reg = issue.instr[15:11];
  assign dest_fp_reg   = issue.instr[10:6];
  assign funct         = issue.instr[5:0];
  assign ceil_op       = (funct == `FN_CEIL_LONG) || (funct == `FN_CEIL_WORD);

  always_comb
  begin
    op     = OP_NONE;
    fmt_ok = 1'b0;
    if (issue.valid && opc == `OPC_FP_COP)
    begin
      if (fmt == `RS_MOVE_FROM && issue.instr[10:0] == 11'h0)
        op = OP_MOVE_FROM;
      else if (fmt == `RS_MOVE_TO && issue.instr[10:0] == 11'h0)
        op = OP_MOVE_TO;
      else if (rt_field == 5'h0 && (ceil_op || funct == `FN_CVT_LONG))
      begin
        fmt_ok = (fmt == `FMT_SINGLE) || (fmt == `FMT_DOUBLE);
        op     = fmt_ok ? OP_TO_FIXED : OP_RESERVED;
      end
      else if (rt_field == 5'h0 && funct == `FN_CVT_DOUBLE)
      begin
        fmt_ok = (fmt == `FMT_SINGLE) || (fmt == `FMT_WORD) || (fmt == `FMT_LONG);
        op     = fmt_ok ? OP_TO_DOUBLE : OP_RESERVED;
      end
    end
  end

  // ****************************************
  // Datapath
  // ****************************************
  logic [31:0] csr_ff;
  logic [1:0]  cur_rm;
  logic [1:0]  fix_rm;
  logic [63:0] fix_result;
  logic        fix_invalid;
  logic        fix_inexact;
  logic [64:0] dbl_out;

  assign cur_rm = csr_ff[`CSR_RM_LSB +: 2];
  assign fix_rm = ceil_op ? `RM_ROUND_UP : cur_rm;

  fp_to_fixed u_fix (
    .is_double (fmt == `FMT_DOUBLE),
    .src       (issue.fp_source),
    .rmode     (fix_rm),
    .to_long   (funct != `FN_CEIL_WORD),
    .result    (fix_result),
    .invalid   (fix_invalid),
    .inexact   (fix_inexact)
  );

  always_comb
  begin
    logic [31:0] w;
    logic [63:0] l;
    logic [7:0]  e8;
    w  = issue.fp_source[31:0];
    l  = issue.fp_source;
    e8 = w[30:23];
    dbl_out = 65'h0;
    if (fmt == `FMT_SINGLE)
    begin
      if (&e8)
        dbl_out = {1'b0, w[31], 11'h7ff, w[22:0], 29'h0};
      else if (e8 == 8'h0)
        dbl_out = int_to_double(w[31], {41'h0, w[22:0]}, -13'sd149, cur_rm);
      else
        dbl_out = int_to_double(w[31], {40'h0, 1'b1, w[22:0]},
                                $signed({5'h0, e8}) - 13'sd150, cur_rm);
    end
    else if (fmt == `FMT_WORD)
      dbl_out = int_to_double(w[31], {32'h0, w[31] ? (~w + 32'h1) : w}, 13'sd0, cur_rm);
    else
      dbl_out = int_to_double(l[63], l[63] ? (~l + 64'h1) : l, 13'sd0, cur_rm);
    // Single and word fit the 53-bit significand
    if (fmt != `FMT_LONG)
      dbl_out[64] = 1'b0;
  end

  // ****************************************
  // Result and status state
  // ****************************************
  wr_port_type fpr_wr_ff;
  wr_port_type nxt_fpr_wr;
  wr_port_type gpr_wr_ff;
  wr_port_type nxt_gpr_wr;
  logic [31:0] nxt_csr;
  logic        exc_ff;
  logic        nxt_exc;
  logic        rsv_ff;
  logic        nxt_rsv;

  always_comb
  begin
    logic [4:0]  cause;
    logic [4:0]  enables;
    logic [31:0] ctl_word;
    nxt_fpr_wr = '0;
    nxt_gpr_wr = '0;
    nxt_csr    = csr_ff;
    nxt_exc    = 1'b0;
    nxt_rsv    = 1'b0;
    cause      = 5'h0;
    enables    = csr_ff[`CSR_EN_LSB +: 5];
    ctl_word   = (source_fp_reg == `FCR_CSR_IDX) ? csr_ff :
                 (source_fp_reg == `FCR_IMPL_IDX) ? IMPL_REV : 32'h0;
    unique case (op)
      OP_NONE: ;
      OP_RESERVED:
        nxt_rsv = 1'b1;
      OP_MOVE_FROM:
      begin
        nxt_gpr_wr.en   = 1'b1;
        nxt_gpr_wr.idx  = rt_field;
        nxt_gpr_wr.data = {{32{ctl_word[31]}}, ctl_word};
      end
      OP_MOVE_TO:
        // Revision register is read-only, other indices are absent
        if (source_fp_reg == `FCR_CSR_IDX)
        begin
          nxt_csr = issue.general_reg_operand[31:0];
          // Trap rides with the committed value in the same cycle
          nxt_exc = (|(nxt_csr[`CSR_CAUSE_LSB +: 5] & nxt_csr[`CSR_EN_LSB +: 5]))
                    | nxt_csr[`CSR_UNIMPL_BIT];
        end
      OP_TO_FIXED, OP_TO_DOUBLE:
      begin
        if (op == OP_TO_FIXED)
        begin
          cause           = {fix_invalid, 3'h0, fix_inexact};
          nxt_fpr_wr.data = fix_result;
        end
        else
        begin
          cause           = {4'h0, dbl_out[64]};
          nxt_fpr_wr.data = dbl_out[63:0];
        end
        nxt_csr[`CSR_CAUSE_LSB +: 6] = {1'b0, cause};
        nxt_csr[`CSR_FLAG_LSB +: 5]  = csr_ff[`CSR_FLAG_LSB +: 5] | cause;
        nxt_exc                      = |(cause & enables);
        // Enabled trap suppresses the destination write
        nxt_fpr_wr.en                = ~nxt_exc;
        nxt_fpr_wr.idx               = dest_fp_reg;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      fpr_wr_ff <= '0;
      gpr_wr_ff <= '0;
      csr_ff    <= `CSR_RESET;
      exc_ff    <= 1'b0;
      rsv_ff    <= 1'b0;
    end
    else
    begin
      fpr_wr_ff <= nxt_fpr_wr;
      gpr_wr_ff <= nxt_gpr_wr;
      csr_ff    <= nxt_csr;
      exc_ff    <= nxt_exc;
      rsv_ff    <= nxt_rsv;
    end
  end

  assign fp_register_wr        = fpr_wr_ff;
  assign general_reg_wr        = gpr_wr_ff;
  assign fp_control_status_reg = csr_ff;
  assign fp_exception          = exc_ff;
  assign reserved_instr        = rsv_ff;

endmodule
`default_nettype wire

// File: bench/fpu_cvt_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpu_cvt_consts.svh"

module fpu_cvt_unit_sva
  import fpu_cvt_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire issue_type   issue,
  input wire wr_port_type fp_register_wr,
  input wire wr_port_type general_reg_wr,
  input wire logic [31:0] fp_control_status_reg,
  input wire logic        fp_exception,
  input wire logic        reserved_instr
);
  // ****************************************
  // Decode helpers
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic cvt;
  logic sd;
  logic mv_to;
  logic [5:0] fn;
  logic [4:0] fmt;
  assign fn  = issue.instr[5:0];
  assign fmt = issue.instr[25:21];
  assign cvt = issue.valid && issue.instr[31:26] == `OPC_FP_COP && issue.instr[20:16] == 5'h00;
  assign sd  = fmt == `FMT_SINGLE || fmt == `FMT_DOUBLE;
  assign mv_to = issue.valid && issue.instr[31:26] == `OPC_FP_COP && fmt == `RS_MOVE_TO
                 && issue.instr[15:11] == `FCR_CSR_IDX && issue.instr[10:0] == 11'h000;

  // ****************************************
  // Properties
  // ****************************************
  property p_long_write;
    cvt && sd && fn == `FN_CEIL_LONG && fp_control_status_reg[11:7] == 5'h00 |=>
      fp_register_wr.en && fp_register_wr.idx == $past(issue.instr[10:6]) && !fp_exception;
  endproperty
  a_long_write: assert property (p_long_write) else $error("long round-up not written");
  property p_word_write;
    cvt && sd && fn == `FN_CEIL_WORD && fp_control_status_reg[11:7] == 5'h00 |=>
      fp_register_wr.en && fp_register_wr.data[63:32] == 32'h0;
  endproperty
  a_word_write: assert property (p_word_write) else $error("word round-up not written");
  property p_trap_no_write;
    fp_exception |-> !fp_register_wr.en;
  endproperty
  a_trap_no_write: assert property (p_trap_no_write) else $error("write during trap");
  property p_flags_sticky;
    cvt && sd && (fn == `FN_CEIL_LONG || fn == `FN_CEIL_WORD) |=>
      (fp_control_status_reg[6:2] & $past(fp_control_status_reg[6:2]))
        == $past(fp_control_status_reg[6:2]);
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("flag lost");
  property p_move_from;
    issue.valid && issue.instr[31:26] == `OPC_FP_COP && fmt == `RS_MOVE_FROM
      && issue.instr[10:0] == 11'h000 |=> general_reg_wr.en
      && general_reg_wr.idx == $past(issue.instr[20:16])
      && general_reg_wr.data[63:32] == {32{general_reg_wr.data[31]}};
  endproperty
  a_move_from: assert property (p_move_from) else $error("move-from wrong");
  property p_move_to;
    mv_to |=> fp_control_status_reg == $past(issue.general_reg_operand[31:0]);
  endproperty
  a_move_to: assert property (p_move_to) else $error("move-to wrong");
  property p_move_to_trap;
    mv_to && (issue.general_reg_operand[16:12] & issue.general_reg_operand[11:7]) != 5'h00
      |=> fp_exception;
  endproperty
  a_move_to_trap: assert property (p_move_to_trap) else $error("no trap on write");
  property p_dbl_range;
    // Reserved formats leave the status alone, so only legal sources count
    cvt && fn == `FN_CVT_DOUBLE && (fmt == `FMT_SINGLE || fmt == `FMT_WORD || fmt == `FMT_LONG)
      |=> fp_control_status_reg[14:13] == 2'h0;
  endproperty
  a_dbl_range: assert property (p_dbl_range) else $error("double overflow raised");
  property p_dbl_exact;
    cvt && fn == `FN_CVT_DOUBLE && (fmt == `FMT_SINGLE || fmt == `FMT_WORD)
      |=> !fp_control_status_reg[12];
  endproperty
  a_dbl_exact: assert property (p_dbl_exact) else $error("inexact on exact source");
  property p_bad_fmt;
    cvt && fn == `FN_CEIL_LONG && !sd |=> reserved_instr && !fp_register_wr.en
      && $stable(fp_control_status_reg);
  endproperty
  a_bad_fmt: assert property (p_bad_fmt) else $error("bad format accepted");
endmodule

bind fpu_cvt_unit fpu_cvt_unit_sva u_sva (.mclk(mclk), .nrst(nrst), .issue(issue),
  .fp_register_wr(fp_register_wr), .general_reg_wr(general_reg_wr),
  .fp_control_status_reg(fp_control_status_reg), .fp_exception(fp_exception),
  .reserved_instr(reserved_instr));
`default_nettype wire

// File: bench/host_issue_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_issue_model
  import fpu_cvt_pkg::*;
(
  input  wire logic      mclk,
  input  wire issue_type want,
  output issue_type      issue
);
  initial issue = '0;
  // Idle operand lanes toggle so a stale value never passes for a live one
  always @(negedge mclk)
  begin
    // One assignment per edge, so no field is driven twice in a time step
    issue <= want.valid ? want
                        : issue_type'{1'b0, want.instr, ~issue.fp_source,
                                      ~issue.general_reg_operand};
  end
endmodule
`default_nettype wire

// File: bench/fpu_convert_and_control_move_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpu_cvt_consts.svh"

module fpu_convert_and_control_move_bench
  import fpu_cvt_pkg::*;
;
  typedef struct packed {
    logic fw, gw, ex, rs;
    logic [4:0] idx;
    logic [63:0] data;
    logic [31:0] csr;
  } note_type;
  localparam logic [31:0] REV = 32'h0000_5a5a;   // Arbitrary identification value
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  issue_type want = '0;
  issue_type issue;
  wr_port_type fw, gw;
  logic [31:0] csr, csr_m = 32'h0;
  logic exc, rsv;
  int miscompares = 0, n_tests = 0;
  note_type notes[$], n;
  real r;
  always #2.5 mclk = ~mclk;
  host_issue_model PEER (.mclk(mclk), .want(want), .issue(issue));
  fpu_cvt_unit #(.IMPL_REV(REV)) DUT (.mclk(mclk), .nrst(nrst), .issue(issue),
    .fp_register_wr(fw), .general_reg_wr(gw), .fp_control_status_reg(csr),
    .fp_exception(exc), .reserved_instr(rsv));

  // ****************************************
  // Checking
  // ****************************************
  task automatic chk(input string what, input logic [68:0] e, input logic [68:0] s);
    n_tests++;
    if (e !== s)
    begin
      $display("[ERR] %s expected %h seen %h", what, e, s);
      miscompares++;
    end
  endtask
  task automatic complete_run;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    #1;
    if (nrst === 1'b1 && (fw.en | gw.en | exc | rsv) === 1'b1)
    begin
      if (notes.size() == 0)
        chk("spare event", 69'h0, 69'h1);
      else
      begin
        n = notes.pop_front();
        chk("events", {n.fw, n.gw, n.ex, n.rs}, {fw.en, gw.en, exc, rsv});
        chk("status", n.csr, csr);
        if (n.fw) chk("fp write", {n.idx, n.data}, {fw.idx, fw.data});
        if (n.gw) chk("gp write", {n.idx, n.data}, {gw.idx, gw.data});
      end
    end
  end

  // ****************************************
  // Stimulus
  // ****************************************
  task automatic op(input logic [31:0] ins, input logic [63:0] src, input logic [63:0] g,
                    input logic ev, input note_type nt);
    @(posedge mclk);
    want <= '{1'b1, ins, src, g};
    if (ev) notes.push_back(nt);
  endtask
  function automatic real rnd(input real x, input logic [1:0] m);
    case (m)
      2'h0: return $floor(x + 0.5);
      2'h1: return (x < 0.0) ? $ceil(x) : $floor(x);
      2'h2: return $ceil(x);
      default: return $floor(x);
    endcase
  endfunction
  task automatic conv(input logic [5:0] fn, input logic [4:0] fmt, input logic [63:0] src,
                      input real x);
    logic lg, v, ix, trap;
    logic [4:0] fd;
    logic [63:0] d;
    real q, lim;
    lg = fn != `FN_CEIL_WORD;
    fd = 5'($urandom);
    q = rnd(x, (fn == `FN_CVT_LONG) ? csr_m[1:0] : `RM_ROUND_UP);
    lim = lg ? 2.0**63 : 2.0**31;
    v = q >= lim || q < -lim;
    ix = !v && q != x;
    // Infinite q must never reach the integer cast
    d = lg ? `LONG_DEFAULT : `WORD_DEFAULT;
    if (!v) d = lg ? longint'(q) : {32'h0, 32'(longint'(q))};
    csr_m[17:12] = {1'b0, v, 3'h0, ix};
    csr_m[6:2] = csr_m[6:2] | {v, 3'h0, ix};
    trap = (v & csr_m[11]) | (ix & csr_m[7]);
    op({`OPC_FP_COP, fmt, 5'h0, 5'h3, fd, fn}, src, 64'h0, 1'b1, '{!trap, 1'b0, trap, 1'b0, fd, d,
       csr_m});
  endtask
  task automatic dbl(input logic [4:0] fmt, input logic [63:0] src, input logic [63:0] e,
                     input logic ix);
    csr_m[17:12] = {5'h0, ix};
    csr_m[2] = csr_m[2] | ix;
    op({`OPC_FP_COP, fmt, 5'h0, 5'h4, 5'h9, `FN_CVT_DOUBLE}, src, 64'h0, 1'b1,
       '{1'b1, 1'b0, 1'b0, 1'b0, 5'h9, e, csr_m});
  endtask
  task automatic mvto(input logic [63:0] g);
    logic t;
    csr_m = g[31:0];
    t = (g[16:12] & g[11:7]) != 5'h00 || g[17];
    op({`OPC_FP_COP, `RS_MOVE_TO, 5'h2, `FCR_CSR_IDX, 11'h0}, 64'h0, g, t,
       '{1'b0, 1'b0, 1'b1, 1'b0, 5'h0, 64'h0, csr_m});
  endtask
  task automatic mvfrom(input logic [4:0] fs);
    logic [31:0] w;
    w = (fs == `FCR_CSR_IDX) ? csr_m : (fs == `FCR_IMPL_IDX) ? REV : 32'h0;
    op({`OPC_FP_COP, `RS_MOVE_FROM, 5'h7, fs, 11'h0}, 64'h0, 64'h0, 1'b1,
       '{1'b0, 1'b1, 1'b0, 1'b0, 5'h7, {{32{w[31]}}, w}, csr_m});
  endtask
  task automatic bad(input logic [5:0] fn, input logic [4:0] fmt);
    op({`OPC_FP_COP, fmt, 5'h0, 5'h1, 5'h2, fn}, 64'h0, 64'h0, 1'b1,
       '{1'b0, 1'b0, 1'b0, 1'b1, 5'h0, 64'h0, csr_m});
  endtask

  initial
  begin
    #20000;
    miscompares++;
    complete_run();
  end
  initial
  begin
    n_tests = $urandom(32'heef0);
    n_tests = 0;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      mvto({$urandom, 30'h0, m[1:0]});
      for (int i = 0; i < 3; i++)
      begin
        r = real'(int'($urandom % 20001) - 10000) / 7.0;
        conv(`FN_CEIL_LONG, `FMT_DOUBLE, $realtobits(r), r);
        conv(`FN_CEIL_WORD, `FMT_DOUBLE, $realtobits(r), r);
        conv(`FN_CVT_LONG, `FMT_DOUBLE, $realtobits(r), r);
      end
    end
    conv(`FN_CEIL_LONG, `FMT_SINGLE, 64'h0000_0000_c010_0000, -2.25);
    conv(`FN_CEIL_LONG, `FMT_DOUBLE, 64'h7ff0_0000_0000_0000,
         $bitstoreal(64'h7ff0_0000_0000_0000));
    conv(`FN_CEIL_WORD, `FMT_DOUBLE, $realtobits(2147483646.5), 2147483646.5);
    conv(`FN_CEIL_WORD, `FMT_DOUBLE, $realtobits(2147483647.5), 2147483647.5);
    conv(`FN_CEIL_WORD, `FMT_DOUBLE, $realtobits(-2147483648.5), -2147483648.5);
    mvto(64'h0000_0000_0000_0080);
    conv(`FN_CEIL_WORD, `FMT_DOUBLE, $realtobits(1.25), 1.25);
    mvto(64'h0000_0000_0000_0800);
    conv(`FN_CEIL_LONG, `FMT_DOUBLE, $realtobits(2.0**64), 2.0**64);
    mvfrom(`FCR_CSR_IDX);
    mvto(64'h0000_0000_0001_0800);
    mvto(64'h1234_5678_8000_0003);
    mvfrom(`FCR_CSR_IDX);
    mvfrom(`FCR_IMPL_IDX);
    mvfrom(5'h05);
    dbl(`FMT_LONG, 64'h0020_0000_0000_0001, 64'h4340_0000_0000_0000, 1'b1);
    mvto(64'h2);
    dbl(`FMT_LONG, 64'h0020_0000_0000_0001, 64'h4340_0000_0000_0001, 1'b1);
    dbl(`FMT_WORD, 64'h0000_0000_ffff_fff9, $realtobits(-7.0), 1'b0);
    dbl(`FMT_SINGLE, 64'h0000_0000_3fc0_0000, $realtobits(1.5), 1'b0);
    bad(`FN_CEIL_LONG, `FMT_WORD);
    bad(`FN_CVT_DOUBLE, `FMT_DOUBLE);
    @(posedge mclk);
    want <= '0;
    repeat (4) @(posedge mclk);
    #2;
    chk("left over", 69'h0, 69'(notes.size()));
    complete_run();
  end
endmodule
`default_nettype wire
